// >>> psr_pkg.sv
// Purpose: shared constants for the loop status readback block
// Assumes: 8-bit registers behind a 24-bit serial configuration frame
// Notes:   offsets are register addresses carried in the frame header
package psr_pkg;

  // serial frame layout: one direction bit, address, then one data byte
  localparam int unsigned PSR_ADDR_BITS   = 15;  // address field width
  localparam int unsigned PSR_HDR_BITS    = 16;  // direction bit plus address
  localparam int unsigned PSR_FRAME_BITS  = 24;  // header plus data byte
  localparam int unsigned PSR_SYNC_STAGES = 2;   // flops before any logic reads a pin

  // bit counter values that mark frame boundaries
  localparam logic [4:0] PSR_CNT_HDR_LAST = 5'h0F;  // last header bit index
  localparam logic [4:0] PSR_CNT_DATA_END = 5'h18;  // count after the last data bit
  localparam logic [4:0] PSR_CNT_RESET    = 5'h00;  // counter after reset

  // register offsets
  localparam logic [14:0] PSR_OFS_REF_LOOP_STATE  = 15'h0082;
  localparam logic [14:0] PSR_OFS_DAC_AVERAGE     = 15'h0083;
  localparam logic [14:0] PSR_OFS_DAC_CURRENT     = 15'h0084;
  localparam logic [14:0] PSR_OFS_REF_LOOP_FLAGS  = 15'h0085;
  localparam logic [14:0] PSR_OFS_EXIT_PHASE      = 15'h0086;
  localparam logic [14:0] PSR_OFS_REF_LOOP_SPARE  = 15'h0087;
  localparam logic [14:0] PSR_OFS_CAP_BANK        = 15'h008C;
  localparam logic [14:0] PSR_OFS_ERROR_LOW       = 15'h008D;
  localparam logic [14:0] PSR_OFS_STATUS_ERR_HIGH = 15'h008E;

  // field positions
  localparam int unsigned PSR_POS_STATE     = 0;  // ref_loop_state [2:0]
  localparam int unsigned PSR_POS_ACTIVE    = 3;  // ref_loop_state [4:3]
  localparam int unsigned PSR_POS_PREFERRED = 5;  // ref_loop_state [6:5]
  localparam int unsigned PSR_POS_COMPARE   = 7;  // holdover_dac_current [7]
  localparam int unsigned PSR_POS_LOS       = 3;  // ref_loop_flags [3]
  localparam int unsigned PSR_POS_FASTER    = 2;  // ref_loop_flags [2]
  localparam int unsigned PSR_POS_ADC_MOVE  = 1;  // ref_loop_flags [1]
  localparam int unsigned PSR_POS_ADC_RANGE = 0;  // ref_loop_flags [0]
  localparam int unsigned PSR_POS_EXIT      = 3;  // holdover_exit_phase [4:3]
  localparam int unsigned PSR_POS_AT_BUSY   = 7;  // status_error_high [7]
  localparam int unsigned PSR_POS_ERR_SIGN  = 6;  // status_error_high [6]

  // reference loop state encodings
  localparam logic [2:0] PSR_REF_RESET     = 3'h0;
  localparam logic [2:0] PSR_REF_ACQUIRE   = 3'h1;
  localparam logic [2:0] PSR_REF_LOCKED    = 3'h2;
  localparam logic [2:0] PSR_REF_INVALID   = 3'h3;
  localparam logic [2:0] PSR_REF_HOLDOVER  = 3'h4;
  localparam logic [2:0] PSR_REF_DAC_EXIT  = 3'h5;

  // values after reset
  localparam logic [7:0] PSR_CAP_BANK_RESET = 8'h00;
  localparam logic [7:0] PSR_READ_NONE      = 8'h00;  // unmapped or reserved

  // serial frame sequencer, one-hot
  typedef enum logic [3:0] {
    psr_idle   = 4'b0001,  // chip select high, pin released
    psr_header = 4'b0010,  // shifting direction and address
    psr_data   = 4'b0100,  // data byte phase
    psr_hold   = 4'b1000   // frame complete, wait for deselect
  } psr_phase_type;

endpackage

// >>> psr_sync.sv
// Purpose: two-flop synchroniser for a group of level signals
// Assumes: each bit is a slow level; no word coherency is promised
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module psr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // metastability catcher, read only by the second stage
  logic [WIDTH-1:0] meta;

  // both stages clear synchronously with the block
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// >>> psr_readback.sv
// Purpose: read-only status bank for the dual-loop jitter attenuator
// Assumes: serial configuration pins sampled by core_clk (50 MHz)
// Notes:   serial clock must stay at or below core_clk / 10
//          status is read live, so a value spanning two registers may tear
`timescale 1ns/1ps
module psr_readback (
  input  wire logic       core_clk,                  // block clock, 50 MHz
  input  wire logic       rst,                       // synchronous, active high
  input  wire logic       spi_sclk,                  // serial clock pin
  input  wire logic       spi_cs_n,                  // chip select pin, active low
  input  wire logic       sdio_in,                   // data pin, input side
  output logic            sdio_out,                  // data pin, output side
  output logic            sdio_oe_n,                 // data pin enable, low drives
  input  wire logic [2:0] reference_loop_state,      // reference loop state machine
  input  wire logic [1:0] preferred_reference,       // priority encoder choice
  input  wire logic [1:0] active_reference,          // input now in use
  input  wire logic [6:0] dac_average,               // averaged holdover DAC code
  input  wire logic [6:0] dac_current,               // present holdover DAC code
  input  wire logic       dac_compare,               // DAC vs tuning voltage
  input  wire logic       active_loss_of_signal,     // active input lost
  input  wire logic       reference_faster,          // some input beats oscillator
  input  wire logic       adc_moving,                // tuning voltage moving fast
  input  wire logic       adc_out_of_range,          // tuning voltage out of range
  input  wire logic [1:0] exit_phase,                // holdover exit phase
  input  wire logic       autotune_busy,             // oscillator loop autotune busy
  input  wire logic [7:0] autotune_cap,              // capacitor bank being chosen
  input  wire logic [13:0] autotune_error,           // error magnitude count
  input  wire logic       autotune_error_negative    // error sign
);

  // width of the status bundle crossing into this domain
  localparam int unsigned STATUS_BITS = 52;
  // synchroniser depth as a settle count, cut to the counter's width
  localparam logic [1:0] SETTLE_DONE = 2'(psr_pkg::PSR_SYNC_STAGES);

  // whole state of the block
  typedef struct packed {
    psr_pkg::psr_phase_type phase;      // frame sequencer
    logic                   sclk_prev;  // serial clock one sample ago
    logic [4:0]             bit_cnt;    // bits seen in this frame
    logic [14:0]            hdr;        // header bits shifted so far
    logic                   rd;         // frame is a read
    logic [7:0]             tx;         // outgoing byte
    logic                   sdo;        // data pin value
    logic                   oe_n;       // data pin enable, low drives
    logic                   busy_prev;  // autotune busy one cycle ago
    logic [7:0]             cap_bank;   // captured capacitor bank
    logic [1:0]             settle;     // cycles since reset, stops at settle count
  } psr_state_type;

  // register and its next value
  psr_state_type q;
  psr_state_type next_q;

  // synchronised pins
  logic [2:0] pins_raw;   // sclk, cs_n, sdio as they arrive
  logic [2:0] pins_sync;  // same after two flops
  logic       sclk_s;     // synced serial clock
  logic       cs_n_s;     // synced chip select
  logic       sdi_s;      // synced data in

  // synchronised status bundle
  logic [STATUS_BITS-1:0] status_raw;   // loop signals as they arrive
  logic [STATUS_BITS-1:0] status_sync;  // same after two flops

  // unpacked synced status
  logic [2:0]  s_state;     // reference loop state
  logic [1:0]  s_pref;      // preferred reference
  logic [1:0]  s_active;    // active reference
  logic [6:0]  s_dac_avg;   // averaged DAC code
  logic [6:0]  s_dac_cur;   // current DAC code
  logic        s_compare;   // comparator
  logic        s_los;       // active input lost
  logic        s_faster;    // input faster than oscillator
  logic        s_adc_move;  // ADC sees fast tuning voltage
  logic        s_adc_range; // ADC input out of range
  logic [1:0]  s_exit;      // exit phase
  logic        s_busy;      // autotune busy
  logic [7:0]  s_cap;       // live capacitor bank
  logic [13:0] s_err;       // error magnitude
  logic        s_sign;      // error sign

  // frame decode helpers
  logic [15:0] hdr_full;   // complete header once the last bit lands
  logic [14:0] rd_addr;    // register address of the frame
  logic [7:0]  read_data;  // byte selected by the address
  logic        rise;       // serial clock rising edge seen
  logic        fall;       // serial clock falling edge seen
  logic        settled;    // synchronisers hold real pin samples

  // pins come from outside this clock domain
  assign pins_raw = {spi_sclk, spi_cs_n, sdio_in};

  // pin synchroniser
  psr_sync #(
    .WIDTH    (3)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign sdi_s  = pins_sync[0];

  // loop state machines run on their own clocks, so every bit is synced
  assign status_raw = {reference_loop_state, preferred_reference, active_reference,
                       dac_average, dac_current, dac_compare, active_loss_of_signal,
                       reference_faster, adc_moving, adc_out_of_range, exit_phase,
                       autotune_busy, autotune_cap, autotune_error,
                       autotune_error_negative};

  // status synchroniser; multi-bit fields may tear for one sample
  psr_sync #(
    .WIDTH    (STATUS_BITS)
  ) u_status_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (status_raw),
    .sync_out (status_sync)
  );

  assign {s_state, s_pref, s_active, s_dac_avg, s_dac_cur, s_compare, s_los,
          s_faster, s_adc_move, s_adc_range, s_exit, s_busy, s_cap, s_err,
          s_sign} = status_sync;

  // serial clock edges from synced samples only
  assign rise = sclk_s & ~q.sclk_prev;
  assign fall = ~sclk_s & q.sclk_prev;

  // the pin synchroniser clears to zero, which reads as chip select low;
  // frames are refused until both stages hold real pin samples
  assign settled = (q.settle == SETTLE_DONE);

  // header as it stands once the sixteenth bit is shifted in
  assign hdr_full = {q.hdr, sdi_s};
  assign rd_addr  = hdr_full[14:0];

  // read mux: live synced status and the captured bank, reserved bits zero
  always_comb
  begin
    read_data = psr_pkg::PSR_READ_NONE;
    // reserved bits stay zero unless a branch fills them
    case (rd_addr)
      // state code and both reference indices
      psr_pkg::PSR_OFS_REF_LOOP_STATE:
      begin
        read_data[psr_pkg::PSR_POS_STATE +: 3]     = s_state;
        read_data[psr_pkg::PSR_POS_PREFERRED +: 2] = s_pref;
        read_data[psr_pkg::PSR_POS_ACTIVE +: 2]    = s_active;
      end
      // averaged holdover DAC code, bit 7 reserved
      psr_pkg::PSR_OFS_DAC_AVERAGE:
      begin
        read_data[6:0] = s_dac_avg;
      end
      // present DAC code with the comparator on top
      psr_pkg::PSR_OFS_DAC_CURRENT:
      begin
        read_data[6:0]                       = s_dac_cur;
        read_data[psr_pkg::PSR_POS_COMPARE]  = s_compare;
      end
      // four live loop flags in the low nibble
      psr_pkg::PSR_OFS_REF_LOOP_FLAGS:
      begin
        read_data[psr_pkg::PSR_POS_LOS]       = s_los;
        read_data[psr_pkg::PSR_POS_FASTER]    = s_faster;
        read_data[psr_pkg::PSR_POS_ADC_MOVE]  = s_adc_move;
        read_data[psr_pkg::PSR_POS_ADC_RANGE] = s_adc_range;
      end
      // exit phase in the middle, the rest reserved
      psr_pkg::PSR_OFS_EXIT_PHASE:
      begin
        read_data[psr_pkg::PSR_POS_EXIT +: 2] = s_exit;
      end
      // whole register reserved
      psr_pkg::PSR_OFS_REF_LOOP_SPARE:
      begin
        read_data = psr_pkg::PSR_READ_NONE;
      end
      // captured bank, not the live search value
      psr_pkg::PSR_OFS_CAP_BANK:
      begin
        read_data = q.cap_bank;
      end
      // low byte of the error count
      psr_pkg::PSR_OFS_ERROR_LOW:
      begin
        read_data = s_err[7:0];
      end
      // busy, sign and upper six error bits
      psr_pkg::PSR_OFS_STATUS_ERR_HIGH:
      begin
        read_data[5:0]                       = s_err[13:8];
        read_data[psr_pkg::PSR_POS_ERR_SIGN] = s_sign;
        read_data[psr_pkg::PSR_POS_AT_BUSY]  = s_busy;
      end
      default:
      begin
        // unmapped addresses answer zero
        read_data = psr_pkg::PSR_READ_NONE;
      end
    endcase
  end

  // next-state logic for the whole block
  always_comb
  begin
    next_q           = q;
    next_q.sclk_prev = sclk_s;
    next_q.busy_prev = s_busy;

    // count out the synchroniser flush after reset
    if (!settled)
    begin
      next_q.settle = q.settle + 2'h1;
    end

    // capture the bank only on busy falling, so a read never sees it mid-search
    if (q.busy_prev && !s_busy)
    begin
      next_q.cap_bank = s_cap;
    end

    if (cs_n_s || !settled)
    begin
      // deselect aborts any frame and frees the pin
      // also taken while the synchronisers still flush after reset
      next_q.phase   = psr_pkg::psr_idle;
      next_q.bit_cnt = psr_pkg::PSR_CNT_RESET;
      next_q.rd      = 1'b0;
      next_q.oe_n    = 1'b1;
      next_q.sdo     = 1'b0;
    end
    else
    begin
      // frame phases while selected
      case (q.phase)
        psr_pkg::psr_idle:
        begin
          // new frame starts with chip select low
          next_q.phase   = psr_pkg::psr_header;
          next_q.bit_cnt = psr_pkg::PSR_CNT_RESET;
        end
        psr_pkg::psr_header:
        begin
          // header bits are sampled on the serial clock rising edge
          if (rise)
          begin
            next_q.hdr     = hdr_full[14:0];
            next_q.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == psr_pkg::PSR_CNT_HDR_LAST)
            begin
              // direction bit set means read; value is taken live here
              next_q.rd    = hdr_full[15];
              next_q.tx    = read_data;
              next_q.phase = psr_pkg::psr_data;
            end
          end
        end
        psr_pkg::psr_data:
        begin
          // reads shift out on falling edges so the host samples on rising
          if (fall && q.rd)
          begin
            next_q.sdo  = q.tx[7];
            next_q.tx   = {q.tx[6:0], 1'b0};
            next_q.oe_n = 1'b0;
          end
          // write data is clocked through and discarded
          if (rise)
          begin
            next_q.bit_cnt = q.bit_cnt + 5'h01;
            if (q.bit_cnt == psr_pkg::PSR_CNT_DATA_END - 5'h01)
            begin
              next_q.phase = psr_pkg::psr_hold;
            end
          end
        end
        psr_pkg::psr_hold:
        begin
          // last bit held until the falling edge after it was sampled
          if (fall)
          begin
            next_q.oe_n = 1'b1;
            next_q.sdo  = 1'b0;
          end
        end
        default:
        begin
          // illegal code: recover to idle with the pin released
          next_q.phase = psr_pkg::psr_idle;
          next_q.oe_n  = 1'b1;
          next_q.sdo   = 1'b0;
        end
      endcase
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      q.phase     <= psr_pkg::psr_idle;
      q.sclk_prev <= 1'b0;
      q.bit_cnt   <= psr_pkg::PSR_CNT_RESET;
      q.hdr       <= '0;
      q.rd        <= 1'b0;
      q.tx        <= psr_pkg::PSR_READ_NONE;
      q.sdo       <= 1'b0;
      q.oe_n      <= 1'b1;
      q.busy_prev <= 1'b0;
      q.cap_bank  <= psr_pkg::PSR_CAP_BANK_RESET;
      q.settle    <= 2'h0;
    end
    else
    begin
      // whole struct moves at once
      q <= next_q;
    end
  end

  // pin outputs straight from flops
  assign sdio_out  = q.sdo;
  assign sdio_oe_n = q.oe_n;

endmodule

// >>> psr_readback_properties.sv
// Purpose: concurrent checks on the serial pins of the status readback block
// Assumes: mode 0 frames of one direction bit, 15 address bits, one data byte
// Notes:   pin-level frame counter leads the block's synchronised view
`timescale 1ns/1ps
module psr_readback_properties (
  input wire logic core_clk,   // block clock
  input wire logic rst,        // synchronous, active high
  input wire logic spi_sclk,   // serial clock pin
  input wire logic spi_cs_n,   // chip select pin, active low
  input wire logic sdio_in,    // resolved data line
  input wire logic sdio_out,   // data driven by the block
  input wire logic sdio_oe_n   // low while the block drives
);
  // frame watch state: rising edges seen and direction bit
  typedef struct packed
  {
    logic [4:0] cnt;     // sclk rises in this frame
    logic       sclk_q;  // sclk one cycle ago
    logic       rw;      // direction bit, 1 reads
  } psr_watch_type;
  psr_watch_type st;     // registered watch state
  psr_watch_type next_st;  // next watch state

  // count pin edges; stop at 24 since later edges are ignored
  always_comb
  begin
    next_st = st;
    next_st.sclk_q = spi_sclk;
    if (spi_cs_n)
      next_st.cnt = 5'h00;  // deselect ends the frame
    else if (spi_sclk && !st.sclk_q && st.cnt != 5'h18)
    begin
      if (st.cnt == 5'h00)
        next_st.rw = sdio_in;  // first bit names the direction
      next_st.cnt = st.cnt + 5'h01;
    end
  end

  // register the watch state
  always_ff @(posedge core_clk)
  begin
    if (rst)
      st <= 7'h00;
    else
      st <= next_st;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_reset_releases: assert property (disable iff (1'b0)
    $fell(rst) |-> sdio_oe_n ##1 sdio_oe_n ##1 sdio_oe_n)
    else $error("data pin driven just after reset");
  chk_idle_low_out: assert property (sdio_oe_n |-> !sdio_out)
    else $error("data output not zero while released");
  chk_deselect_release: assert property (spi_cs_n [*5] |-> sdio_oe_n)
    else $error("data pin still driven after deselect");
  chk_drive_starts_low: assert property ($fell(sdio_oe_n) |-> !spi_cs_n && !spi_sclk)
    else $error("drive began outside a selected low clock phase");
  chk_bit_moves_low: assert property ($changed(sdio_out) |-> !spi_sclk)
    else $error("output bit changed while serial clock high");
  chk_write_silent: assert property (!sdio_oe_n |-> st.rw)
    else $error("data pin driven during a write frame");
  chk_header_first: assert property (!sdio_oe_n |-> st.cnt >= 5'h10)
    else $error("data pin driven before the header ended");
  chk_frame_end_release: assert property
    ((st.cnt == 5'h18 && !spi_sclk) [*6] |-> sdio_oe_n)
    else $error("data pin still driven after the last bit");

  cov_read_answer: cover property ($fell(sdio_oe_n));
  cov_read_frame: cover property (st.cnt == 5'h18 && st.rw);
  cov_write_frame: cover property (st.cnt == 5'h18 && !st.rw);
endmodule

bind psr_readback psr_readback_properties chk (
  .core_clk  (core_clk),
  .rst       (rst),
  .spi_sclk  (spi_sclk),
  .spi_cs_n  (spi_cs_n),
  .sdio_in   (sdio_in),
  .sdio_out  (sdio_out),
  .sdio_oe_n (sdio_oe_n)
);

// >>> psr_host_model.sv
// Purpose: host side of the serial configuration port
// Assumes: mode 0, six core clocks per serial clock half period
// Notes:   a released line toggles every bit so stale data never reads back
`timescale 1ns/1ps
module psr_host_model (
  input  wire logic core_clk,   // block clock, pins move on its falling edge
  input  wire logic sdio_out,   // block data output
  input  wire logic sdio_oe_n,  // block drive enable, low drives
  output logic      spi_sclk,   // serial clock, still outside frames
  output logic      spi_cs_n,   // chip select, active low
  output logic      sdio_in     // resolved data line
);
  localparam int HALF = 6;  // core clocks per half period, above the 5 minimum
  logic host_bit;           // what the host puts on the line

  // line level from the block's enable; the host drives whenever it is released
  assign sdio_in = sdio_oe_n ? host_bit : sdio_out;

  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    host_bit = 1'b0;
  end

  task automatic wait_half;
    repeat (HALF) @(negedge core_clk);
  endtask

  // one whole frame, msb first; read data taken at each of the last eight rising edges
  task automatic xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [23:0] f;
    f = {rw, addr, wd};
    rd = 8'h00;
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    wait_half();
    for (int i = 0; i < 24; i++)
    begin
      if (i < 16 || !rw)
        host_bit = f[23-i];  // header or write data
      else
        host_bit = ~host_bit;  // released while the block answers
      wait_half();
      spi_sclk = 1'b1;
      if (i >= 16)
        rd[23-i] = sdio_in;
      wait_half();
      spi_sclk = 1'b0;
    end
    wait_half();
    spi_cs_n = 1'b1;
    host_bit = ~host_bit;
    wait_half();
  endtask
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the loop status readback block
// Assumes: status inputs change on the falling edge, well ahead of reads
// Notes:   expectations come from field layouts, never from the block
`timescale 1ns/1ps
module tb;
  logic        core_clk, rst, spi_sclk, spi_cs_n, sdio_in, sdio_out, sdio_oe_n;
  logic [2:0]  reference_loop_state;   // state code under test
  logic [1:0]  preferred_reference, active_reference, exit_phase;
  logic [6:0]  dac_average, dac_current;
  logic        dac_compare, active_loss_of_signal, reference_faster;
  logic        adc_moving, adc_out_of_range, autotune_busy, autotune_error_negative;
  logic [7:0]  autotune_cap;           // bank offered by autotune
  logic [13:0] autotune_error;         // error magnitude
  int          errors, total_checks;   // mismatch and comparison counts

  psr_readback uut (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .reference_loop_state(reference_loop_state), .preferred_reference(preferred_reference),
    .active_reference(active_reference), .dac_average(dac_average),
    .dac_current(dac_current), .dac_compare(dac_compare),
    .active_loss_of_signal(active_loss_of_signal), .reference_faster(reference_faster),
    .adc_moving(adc_moving), .adc_out_of_range(adc_out_of_range), .exit_phase(exit_phase),
    .autotune_busy(autotune_busy), .autotune_cap(autotune_cap),
    .autotune_error(autotune_error), .autotune_error_negative(autotune_error_negative));
  psr_host_model host (.core_clk(core_clk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .sdio_in(sdio_in));

  // 50 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // read one register and compare
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] g;
    host.xfer(1'b1, a, 8'h00, g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: addr %h read %h want %h", $time, a, g, e);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] g;
    host.xfer(1'b0, a, d, g);
  endtask

  task automatic conclude;
    $display("errors %0d total_checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, about three times the expected run
  initial
  begin
    repeat (25000) @(posedge core_clk);
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    errors = 0;
    total_checks = 0;
    rst = 1'b1;
    {reference_loop_state, preferred_reference, active_reference, exit_phase} = 9'h000;
    {dac_average, dac_current, dac_compare} = 15'h0000;
    {active_loss_of_signal, reference_faster, adc_moving, adc_out_of_range} = 4'h0;
    {autotune_busy, autotune_error_negative, autotune_cap, autotune_error} = 24'h000000;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    repeat (4) @(negedge core_clk);
    // every state code with moving input indices
    for (int i = 0; i < 6; i++)
    begin
      reference_loop_state = i[2:0];
      preferred_reference = i[1:0];
      active_reference = ~i[1:0];
      rd(15'h0082, {1'b0, i[1:0], ~i[1:0], i[2:0]});
    end
    $display("test state fields done");
    // holdover codes, flags in both patterns, exit phase
    dac_average = 7'h7F;
    dac_current = 7'h2A;
    dac_compare = 1'b1;
    {active_loss_of_signal, reference_faster, adc_moving, adc_out_of_range} = 4'hA;
    exit_phase = 2'h3;
    rd(15'h0083, 8'h7F);
    rd(15'h0084, 8'hAA);
    rd(15'h0085, 8'h0A);
    rd(15'h0086, 8'h18);
    {active_loss_of_signal, reference_faster, adc_moving, adc_out_of_range} = 4'h5;
    rd(15'h0085, 8'h05);
    $display("test holdover fields done");
    // reserved, unmapped, writes ignored
    rd(15'h0087, 8'h00);
    rd(15'h0088, 8'h00);
    rd(15'h4082, 8'h00);
    wr(15'h0082, 8'hFF);
    rd(15'h0082, {1'b0, 2'h1, 2'h2, 3'h5});
    wr(15'h008C, 8'hFF);
    rd(15'h008C, 8'h00);
    $display("test read only done");
    // autotune: bank loads only when busy ends
    autotune_busy = 1'b1;
    autotune_cap = 8'h5A;
    autotune_error = 14'h2A5C;
    autotune_error_negative = 1'b1;
    rd(15'h008E, 8'hEA);
    rd(15'h008D, 8'h5C);
    rd(15'h008C, 8'h00);
    autotune_busy = 1'b0;
    rd(15'h008C, 8'h5A);
    autotune_cap = 8'h33;
    autotune_error = 14'h15A3;
    autotune_error_negative = 1'b0;
    rd(15'h008E, 8'h15);
    rd(15'h008D, 8'hA3);
    rd(15'h008C, 8'h5A);
    $display("test autotune done");
    // second reset clears the bank
    @(negedge core_clk) rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    rd(15'h008C, 8'h00);
    $display("test second reset done");
    conclude();
  end
endmodule
